// ==== rtc_countdown_timer.sv ====
// countdown timer of a real-time clock, registers over ahb-lite
// assumes a single 100 MHz clock and a pull-up on the interrupt pin
//
// Summary of operation
// (R01) timer counts only while the run enable bit of main control is one
// (R02) selector picks source clock 32 Hz, 8 Hz, 1 Hz or 0.5 Hz
// (R03) sixteen-bit start value: low byte at 18h, high byte at 19h
// (R04) a start value of zero produces no countdown, only the zero-start event
// (R05) a countdown ends when the running count reaches zero
// (R06) with auto reload set, value reloads and the next period starts
// (R07) reload costs one source clock: first period n, later ones n+1
// (R08) countdown end sets the done flag when its interrupt enable is set
// (R09) interrupt pin follows done flag until host writes zero to it
// (R10) selector and auto reload writable only while timer is stopped
// (R11) value bytes writable only while run and auto reload are both zero
// (R12) reset: timer and reload off, 32 Hz source, interrupt enables clear
// (R13) interrupt pin is open drain, active low, never driven high
// (R14) counter decrements once per selected source clock edge
// (R15) value registers read back the programmed value, not the count
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_cfg.svh"

module rtc_countdown_timer #(
  parameter int unsigned SRC_BASE_CYCLES =
    `SRC_BASE_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt pin, open drain
  output logic             int_n_o,
  output logic             int_n_oe,
  // system interrupt
  output logic             irq
);

  // register address match on a word slot
  function automatic logic hit(input logic [31:0] addr,
                               input logic [7:0]  idx);
    hit = (addr == {22'h0, idx, 2'b00});
  endfunction

  // bus side
  logic        wr_en;
  logic        rd_en;
  logic [31:0] acc_addr;
  logic [7:0]  wdata;
  logic [31:0] rd_data;

  // registers
  rtc_timer_pkg::reg_byte_type ctrl_q;
  rtc_timer_pkg::reg_byte_type ctrl_d;
  rtc_timer_pkg::reg_byte_type irq_ctrl_q;
  rtc_timer_pkg::reg_byte_type irq_ctrl_d;
  rtc_timer_pkg::reg_byte_type val_lo_q;
  rtc_timer_pkg::reg_byte_type val_lo_d;
  rtc_timer_pkg::reg_byte_type val_hi_q;
  rtc_timer_pkg::reg_byte_type val_hi_d;
  logic                        done_q;
  logic                        done_d;
  logic [`EVT_WIDTH-1:0]       evt_q;
  logic [`EVT_WIDTH-1:0]       evt_d;
  logic [`EVT_WIDTH-1:0]       mask_q;
  logic [`EVT_WIDTH-1:0]       mask_d;
  logic                        irq_q;
  logic                        pin_oe_q;
  logic                        run_prev_q;

  // countdown engine
  rtc_timer_pkg::cd_state_type state_q;
  rtc_timer_pkg::cd_state_type state_d;
  logic [15:0]                 cnt_q;
  logic [15:0]                 cnt_d;
  logic                        tick;
  wire  [1:0]                  src_sel;
  wire                         src_run;

  // prescaler phase restarts at every start, so the first period is whole
  src_tick_gen #(
    .BASE_CYCLES (SRC_BASE_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .run  (src_run),
    .sel  (src_sel),
    .tick (tick)
  );

  ahb_word_port u_port (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .acc_addr  (acc_addr),
    .wr_data   (wdata),
    .rd_data   (rd_data)
  );

  // control fields, read live; the lock keeps selector, auto reload and value steady while running
  wire        run_en;
  wire        auto_reload;
  wire [15:0] reload_val;
  wire        cd_irq_en;

  assign run_en      = ctrl_q[`BIT_RUN_ENABLE];
  assign auto_reload = ctrl_q[`BIT_AUTO_RELOAD];
  assign src_sel     = {ctrl_q[`BIT_SEL_HI], ctrl_q[`BIT_SEL_LO]}; // R02
  assign reload_val  = {val_hi_q, val_lo_q}; // R03
  assign cd_irq_en   = irq_ctrl_q[`BIT_CD_IRQ];

  // prescaler runs only while a period is in progress
  assign src_run = (state_q == rtc_timer_pkg::ST_COUNT) ||
                   (state_q == rtc_timer_pkg::ST_RELOAD);

  // address decode, shared by the write strobes and the read mux
  // each slot is one aligned word; byte lanes are not decoded
  wire slot_ctrl;
  wire slot_irq_ctrl;
  wire slot_flag;
  wire slot_lo;
  wire slot_hi;
  wire slot_status;
  wire slot_mask;
  wire slot_run_state;

  assign slot_ctrl      = hit(acc_addr, `IDX_MAIN_CTRL);
  assign slot_irq_ctrl  = hit(acc_addr, `IDX_IRQ_CTRL);
  assign slot_flag      = hit(acc_addr, `IDX_IRQ_FLAG);
  assign slot_lo        = hit(acc_addr, `IDX_VALUE_LOW);
  assign slot_hi        = hit(acc_addr, `IDX_VALUE_HIGH);
  assign slot_status    = hit(acc_addr, `IDX_EVT_STATUS);
  assign slot_mask      = hit(acc_addr, `IDX_EVT_MASK);
  assign slot_run_state = hit(acc_addr, `IDX_RUN_STATE);

  // write decode
  wire wr_ctrl;
  wire wr_irq_ctrl;
  wire wr_flag;
  wire wr_lo;
  wire wr_hi;
  wire wr_status;
  wire wr_mask;
  wire val_open;

  assign wr_ctrl     = wr_en && slot_ctrl;
  assign wr_irq_ctrl = wr_en && slot_irq_ctrl;
  assign wr_flag     = wr_en && slot_flag;
  assign wr_lo       = wr_en && slot_lo;
  assign wr_hi       = wr_en && slot_hi;
  assign wr_status   = wr_en && slot_status;
  assign wr_mask     = wr_en && slot_mask;
  // checked on the current ctrl, so one write cannot both stop and load
  assign val_open    = !run_en && !auto_reload; // R11

  // locked fields keep their value while the timer runs
  wire [7:0] ctrl_lock;

  assign ctrl_lock = run_en ? `CTRL_LOCK_MASK : 8'h00; // R10
  assign ctrl_d    = wr_ctrl ? ((wdata & ~ctrl_lock) | (ctrl_q & ctrl_lock))
                             : ctrl_q;
  assign irq_ctrl_d = wr_irq_ctrl ? (wdata & `IRQ_CTRL_MASK) : irq_ctrl_q;
  assign val_lo_d   = (wr_lo && val_open) ? wdata : val_lo_q; // R11
  assign val_hi_d   = (wr_hi && val_open) ? wdata : val_hi_q; // R11

  // countdown events
  // a zero start is its own event; the engine never leaves idle
  wire run_rise;
  wire cd_end;
  wire zero_start;

  assign run_rise   = run_en && !run_prev_q;
  assign cd_end     = (state_q == rtc_timer_pkg::ST_COUNT) && tick &&
                      (cnt_q == 16'h0001); // R05
  assign zero_start = run_rise && (reload_val == 16'h0000); // R04

  // flag set wins over a clear written in the same cycle
  wire flag_clear;

  // writing a one to the flag has no effect
  assign flag_clear = wr_flag && !wdata[`BIT_CD_IRQ]; // R09
  assign done_d = (cd_end && cd_irq_en) || (done_q && !flag_clear); // R08

  // sticky event status, write one to clear, set wins
  wire [`EVT_WIDTH-1:0] evt_set;
  wire [`EVT_WIDTH-1:0] evt_clr;

  assign evt_set = {zero_start, cd_end};
  assign evt_clr = wr_status ? wdata[`EVT_WIDTH-1:0] : '0;
  assign evt_d   = evt_set | (evt_q & ~evt_clr);
  assign mask_d  = wr_mask ? wdata[`EVT_WIDTH-1:0] : mask_q;

  // countdown state machine
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      rtc_timer_pkg::ST_IDLE: begin
        // zero value leaves the timer effectively stopped
        if (run_en && reload_val != 16'h0000) begin // R01 R04
          state_d = rtc_timer_pkg::ST_COUNT;
          cnt_d   = reload_val;
        end
      end
      rtc_timer_pkg::ST_COUNT: begin
        if (tick) begin
          cnt_d = cnt_q - 16'h0001; // R14
          if (cnt_q == 16'h0001) begin
            state_d = auto_reload ? rtc_timer_pkg::ST_RELOAD // R06
                                  : rtc_timer_pkg::ST_HOLD;
          end
        end
      end
      rtc_timer_pkg::ST_RELOAD: begin
        // reload spends one whole source clock
        if (tick) begin // R07
          state_d = rtc_timer_pkg::ST_COUNT;
          cnt_d   = reload_val; // R06
        end
      end
      rtc_timer_pkg::ST_HOLD: begin
        // without reload the count parks at zero until run is cleared
        state_d = rtc_timer_pkg::ST_HOLD;
      end
      default: begin
        // an illegal code falls back to idle rather than hanging
        state_d = rtc_timer_pkg::ST_IDLE;
      end
    endcase
    // stopping overrides every state
    if (!run_en) begin // R01
      state_d = rtc_timer_pkg::ST_IDLE;
    end
  end

  // read mux; unmapped slots and idle cycles read zero
  wire [31:0] ctrl_word;
  wire [31:0] irq_ctrl_word;
  wire [31:0] flag_word;
  wire [31:0] lo_word;
  wire [31:0] hi_word;
  wire [31:0] status_word;
  wire [31:0] mask_word;
  wire [31:0] run_word;

  assign ctrl_word     = {24'h0, ctrl_q};
  assign irq_ctrl_word = {24'h0, irq_ctrl_q};
  assign flag_word     = {30'h0, done_q, 1'b0};
  // value slots show the programmed value; the live count is in run state
  assign lo_word       = {24'h0, val_lo_q}; // R15
  assign hi_word       = {24'h0, val_hi_q}; // R15
  assign status_word   = {30'h0, evt_q};
  assign mask_word     = {30'h0, mask_q};
  assign run_word      = {15'h0, src_run, cnt_q};
  assign rd_data  =
    !rd_en         ? 32'h0 :
    slot_ctrl      ? ctrl_word :
    slot_irq_ctrl  ? irq_ctrl_word :
    slot_flag      ? flag_word :
    slot_lo        ? lo_word :
    slot_hi        ? hi_word :
    slot_status    ? status_word :
    slot_mask      ? mask_word :
    slot_run_state ? run_word : 32'h0;

  // pin and system interrupt straight from flops
  // open drain: the level is always low, only the enable toggles
  assign int_n_o  = 1'b0; // R13
  assign int_n_oe = pin_oe_q;
  assign irq      = irq_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= `MAIN_CTRL_RST; // R12
      irq_ctrl_q <= `IRQ_CTRL_RST; // R12
      val_lo_q   <= 8'h00;
      val_hi_q   <= 8'h00;
      run_prev_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      irq_ctrl_q <= irq_ctrl_d;
      val_lo_q   <= val_lo_d;
      val_hi_q   <= val_hi_d;
      run_prev_q <= run_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rtc_timer_pkg::ST_IDLE;
      cnt_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      evt_q  <= '0;
      mask_q <= '0;
    end else begin
      done_q <= done_d;
      evt_q  <= evt_d;
      mask_q <= mask_d;
    end
  end

  // outputs use next-state values so they land with the flag itself
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      irq_q    <= |(evt_d & mask_d);
      pin_oe_q <= done_d; // R09 R13
    end
  end

endmodule
`default_nettype wire

// ==== rtc_timer_cfg.svh ====
// offsets, field positions, reset values and timing counts of the timer
// assumes a 100 MHz system clock and word-aligned register slots
`ifndef RTC_TIMER_CFG_SVH
`define RTC_TIMER_CFG_SVH

// clock and source clock timing
`define CLK_PERIOD_NS        10
`define SRC_BASE_PERIOD_NS   31250000

// register indices, byte address is four times the index
`define IDX_MAIN_CTRL        8'h00
`define IDX_IRQ_CTRL         8'h01
`define IDX_IRQ_FLAG         8'h02
`define IDX_VALUE_LOW        8'h18
`define IDX_VALUE_HIGH       8'h19
`define IDX_EVT_STATUS       8'h20
`define IDX_EVT_MASK         8'h21
`define IDX_RUN_STATE        8'h22

// main control fields
`define BIT_RUN_ENABLE       1
`define BIT_AUTO_RELOAD      2
`define BIT_SEL_LO           5
`define BIT_SEL_HI           6
`define CTRL_LOCK_MASK       8'h64
`define MAIN_CTRL_RST        8'h99

// interrupt control and flag fields
`define BIT_CD_IRQ           1
`define IRQ_CTRL_MASK        8'h1f
`define IRQ_CTRL_RST         8'h00

// event status bits
`define EVT_DONE             0
`define EVT_ZERO_START       1
`define EVT_WIDTH            2

// source clock divider masks over 32 Hz base ticks
`define DIV_MASK_8HZ         6'h03
`define DIV_MASK_1HZ         6'h1f
`define DIV_MASK_HALF_HZ     6'h3f

// bus
`define HSIZE_WORD           3'b010
`endif

// ==== rtc_timer_pkg.sv ====
// types shared by the countdown timer files
// assumes the constants of rtc_timer_cfg.svh
`default_nettype none
package rtc_timer_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_COUNT  = 4'b0010,
    ST_RELOAD = 4'b0100,
    ST_HOLD   = 4'b1000
  } cd_state_type;

  typedef logic [7:0] reg_byte_type;

endpackage
`default_nettype wire

// ==== src_tick_gen.sv ====
// source clock tick generator: one-cycle pulse per selected source period
// assumes run is held high for the whole countdown
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_cfg.svh"

module src_tick_gen #(
  parameter int unsigned BASE_CYCLES = `SRC_BASE_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // tick
  output logic            tick
);

  logic [31:0] base_q;
  logic [5:0]  div_q;
  logic        tick_q;
  wire         base_hit;
  wire  [5:0]  sel_mask;
  wire         sel_hit;

  // phase restarts with run, so the first period is whole
  assign base_hit = run && (base_q == BASE_CYCLES - 32'd1);
  assign sel_mask = (sel == 2'b00) ? 6'h00 :
                    (sel == 2'b01) ? `DIV_MASK_8HZ :
                    (sel == 2'b10) ? `DIV_MASK_1HZ : `DIV_MASK_HALF_HZ;
  assign sel_hit  = (div_q & sel_mask) == sel_mask;
  assign tick     = tick_q;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      base_q <= 32'h0;
      div_q  <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      base_q <= base_hit ? 32'h0 : base_q + 32'd1;
      div_q  <= base_hit ? div_q + 6'h01 : div_q;
      tick_q <= base_hit && sel_hit;
    end
  end

endmodule
`default_nettype wire

// ==== ahb_word_port.sv ====
// ahb-lite slave front end: word transfers, zero-wait writes,
// reads with one wait state so read data always reflect earlier writes
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_cfg.svh"

module ahb_word_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // register side
  output logic             wr_en,
  output logic             rd_en,
  output logic      [31:0] acc_addr,
  output logic      [7:0]  wr_data,
  input  wire logic [31:0] rd_data
);

  logic [31:0] addr_q;
  logic        pend_wr_q;
  logic        pend_rd_q;
  logic [31:0] hrdata_q;
  logic        ready_q;
  logic        resp_q;
  wire         take;

  // other sizes are answered OKAY and otherwise ignored
  assign take      = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);
  assign wr_en     = pend_wr_q;
  assign rd_en     = pend_rd_q;
  assign acc_addr  = addr_q;
  assign wr_data   = hwdata[7:0];
  assign hrdata    = hrdata_q;
  assign hreadyout = ready_q;
  assign hresp     = resp_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q    <= 32'h0;
      pend_wr_q <= 1'b0;
      pend_rd_q <= 1'b0;
      hrdata_q  <= 32'h0;
      ready_q   <= 1'b1;
      resp_q    <= 1'b0;
    end else begin
      addr_q    <= take ? haddr : addr_q;
      pend_wr_q <= take && hwrite;
      pend_rd_q <= take && !hwrite;
      hrdata_q  <= pend_rd_q ? rd_data : hrdata_q;
      ready_q   <= !(take && !hwrite);
      resp_q    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== rtc_timer_chk_sva.sv ====
// checker: bus timing and interrupt pin of the countdown timer
// assumes it is bound to rtc_countdown_timer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupts
  input wire logic        int_n_o,
  input wire logic        int_n_oe,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic flag_wr_q;
  wire  taken = hsel && htrans[1] && hready && hsize == 3'h2;
  // data phase of a flag write; a zero in bit 1 clears at its closing edge
  wire  clr_now = flag_wr_q && !hwdata[1];
  always_ff @(posedge clk) begin
    flag_wr_q <= !rst && taken && hwrite && haddr == 32'h8;
  end
  property p_pin_low; int_n_o == 1'h0; endproperty
  property p_rst_quiet;
    disable iff (1'h0) rst |=> !int_n_oe && !irq && hreadyout;
  endproperty
  property p_read_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  property p_ready_one; !hreadyout |=> hreadyout; endproperty
  property p_write_nowait; taken && hwrite |=> hreadyout; endproperty
  property p_resp_okay; hresp == 1'h0; endproperty
  property p_flag_clear; clr_now |=> !int_n_oe; endproperty
  property p_oe_hold; int_n_oe && !clr_now |=> int_n_oe; endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("interrupt pin driven high");
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  a_ready_one: assert property (p_ready_one)
    else $error("wait state longer than one cycle");
  a_write_nowait: assert property (p_write_nowait)
    else $error("write inserted a wait state");
  a_resp_okay: assert property (p_resp_okay)
    else $error("error response seen");
  a_flag_clear: assert property (p_flag_clear)
    else $error("pin still low after flag cleared");
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin released without flag clear");
  c_oe_rise: cover property ($rose(int_n_oe));
  c_irq_rise: cover property ($rose(irq));
  c_clear: cover property (clr_now ##1 !int_n_oe);
endmodule
bind rtc_countdown_timer rtc_timer_chk u_rtc_timer_chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .int_n_o(int_n_o), .int_n_oe(int_n_oe), .irq(irq));
`default_nettype wire

// ==== ahb_host_model.sv ====
// host model: ahb-lite master issuing single word transfers
// assumes hready is the one slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  // clock
  input  wire logic        clk,
  // bus answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // no pipelining: simpler, costs one idle cycle per transfer
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
    // released data must not look like the last value
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// ==== tb_rtc_countdown_timer.sv ====
// testbench: registers, countdown timing and interrupt pin of the timer
// assumes base tick shortened to 4 cycles and a pull-up on the pin
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_countdown_timer;
  localparam int unsigned BASE = 4;
  typedef struct {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_type;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  wire         hsel, hwrite, hreadyout, hresp, int_n_o, int_n_oe, irq;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire         pin = int_n_oe ? int_n_o : 1'h1;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0, t1, t2;
  int          div [4] = '{1, 4, 32, 64};
  logic [31:0] r;
  row_type     rows [7] = '{
    '{1'h0, 32'h0, 32'h0, 32'h99}, '{1'h0, 32'h4, 32'h0, 32'h0},
    '{1'h1, 32'h4, 32'hff, 32'h1f}, '{1'h1, 32'h60, 32'h3, 32'h3},
    '{1'h1, 32'h64, 32'h0, 32'h0}, '{1'h1, 32'h84, 32'h1, 32'h1},
    '{1'h1, 32'hfc, 32'hff, 32'h0}};

  always #5 clk = ~clk;

  rtc_countdown_timer #(.SRC_BASE_CYCLES(BASE)) u_rtc_countdown_timer (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe), .irq(irq));
  ahb_host_model u_ahb_host_model (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_rng(input string n, input int v, input int lo,
                         input int hi);
    check(n, {31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_ahb_host_model.xfer(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a);
    u_ahb_host_model.xfer(1'h0, a, 32'h0, r);
  endtask
  // two edges first so a just-cleared irq is not mistaken for a new one
  task automatic wait_irq(output int t);
    repeat (2) @(posedge clk);
    while (irq !== 1'h1) @(posedge clk);
    t = cyc;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("reg row", r, rows[i].e);
    end
    // every source clock, n = 3; last one without the pin enable
    for (int s = 0; s < 4; s++) begin
      wr(32'h4, (s == 3) ? 32'h0 : 32'h2);
      wr(32'h0, {25'h0, s[1:0], 5'h0});
      wr(32'h80, 32'h3);
      wr(32'h8, 32'h0);
      wr(32'h0, {25'h0, s[1:0], 5'h2});
      check("pin idle", {31'h0, pin}, 32'h1);
      t0 = cyc;
      wait_irq(t1);
      chk_rng("period", t1 - t0, 3 * BASE * div[s] - 1,
              3 * BASE * div[s] + 4);
      check("pin low", {31'h0, pin}, {31'h0, s == 3});
    end
    // auto reload at 8 Hz; the host stops the timer before reconfiguring
    wr(32'h0, 32'h0);
    wr(32'h0, 32'h24);
    wr(32'h60, 32'h9);
    rd(32'h60);
    check("value locked", r, 32'h3);
    wr(32'h4, 32'h2);
    wr(32'h80, 32'h3);
    wr(32'h8, 32'h0);
    wr(32'h0, 32'h26);
    t0 = cyc;
    wait_irq(t1);
    wr(32'h80, 32'h1);
    rd(32'h88);
    check("run state", r, 32'h10000);
    wait_irq(t2);
    chk_rng("first", t1 - t0, 3 * 4 * BASE - 1, 3 * 4 * BASE + 4);
    check("reload", t2 - t1, 4 * 4 * BASE);
    wr(32'h0, 32'h62);
    rd(32'h0);
    check("ctrl locked", r, 32'h26);
    wr(32'h64, 32'h1);
    rd(32'h64);
    check("high locked", r, 32'h0);
    rd(32'h60);
    check("readback", r, 32'h3);
    wr(32'h0, 32'h24);
    wr(32'h80, 32'h1);
    repeat (100) @(posedge clk);
    check("stopped", {31'h0, irq}, 32'h0);
    // zero start: only the masked zero-start bit may appear
    wr(32'h0, 32'h0);
    wr(32'h60, 32'h0);
    wr(32'h80, 32'h3);
    wr(32'h0, 32'h2);
    repeat (40) @(posedge clk);
    rd(32'h80);
    check("zero start", r, 32'h2);
    check("masked", {31'h0, irq}, 32'h0);
    check("pin held", {31'h0, pin}, 32'h0);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check("pin reset", {31'h0, pin}, 32'h1);
    rd(32'h0);
    check("ctrl reset", r, 32'h99);
    end_sim();
  end
endmodule
`default_nettype wire
